// ---- shared/ccfc_pkg.sv ----
// shared constants, types and helpers of the capture/compare flag control block
package ccfc_pkg;

   // register indexes; byte address is four times the index
   localparam logic [9:0] IDX_MODE   = 10'h120;
   localparam logic [9:0] IDX_STATUS = 10'h123;
   localparam logic [9:0] IDX_IOC_AB = 10'h124;
   localparam logic [9:0] IDX_IOC_CD = 10'h125;
   localparam logic [9:0] IDX_FILTER = 10'h126;
   localparam logic [9:0] IDX_TRIG   = 10'h127;
   localparam logic [9:0] IDX_GR_A   = 10'h128;
   localparam logic [9:0] IDX_COUNT  = 10'h12C;
   localparam logic [9:0] IDX_IMASK  = 10'h12D;

   // values after reset
   localparam logic [7:0]  RST_MODE   = 8'h48;
   localparam logic [7:0]  RST_IOC    = 8'h88;
   localparam logic [7:0]  RST_FILTER = 8'h00;
   localparam logic [1:0]  RST_TRIG   = 2'h0;
   localparam logic [15:0] RST_GR     = 16'hFFFF;
   localparam logic [15:0] RST_COUNT  = 16'h0000;
   localparam logic [4:0]  RST_IMASK  = 5'h00;

   // field positions and forced-one bits
   localparam int          MODE_TRIGGERED_PULSE_MODE_N = 3;
   localparam int          MODE_BFC    = 4;
   localparam int          MODE_BFD    = 5;
   localparam int          MODE_START  = 7;
   localparam logic [7:0]  MODE_ONES   = 8'h40;
   localparam logic [7:0]  IOC_ONES    = 8'h88;
   localparam logic [2:0]  STAT_ONES   = 3'h7;
   localparam int          CAP_SEL     = 2;
   localparam int          FILT_TRIG   = 4;
   localparam logic [15:0] COUNT_TOP   = 16'hFFFF;

   // input filter needs this many equal samples
   localparam int FILTER_MATCHES = 3;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic        en;
      logic [9:0]  idx;
      logic [31:0] data;
      logic [3:0]  be;
   } ccfc_wr_s;

   typedef struct packed {
      logic       en;
      logic [9:0] idx;
   } ccfc_rd_s;

   function automatic logic ccfc_mapped(input logic [9:0] idx);
      return (idx == IDX_MODE) || ((idx >= IDX_STATUS) && (idx <= IDX_IMASK));
   endfunction

   function automatic logic [15:0] ccfc_merge16(input logic [15:0] old,
                                                input logic [15:0] nw,
                                                input logic [1:0]  be);
      return {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
   endfunction

endpackage

// ---- rtl/ccfc_axil.sv ----
// AXI4-Lite slave front end for the capture/compare register file
`timescale 1ns/1ps
module ccfc_axil
   import ccfc_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   // write channels
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // read channels
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // register file side
   output ccfc_wr_s         wr,
   output ccfc_rd_s         rd,
   input  wire logic [31:0] rd_data
);
   logic        aw_held, next_aw_held, w_held, next_w_held;
   logic [11:0] awaddr_q, next_awaddr;
   logic [31:0] wdata_q, next_wdata;
   logic [3:0]  wstrb_q, next_wstrb;
   logic        next_awready, next_wready, next_arready, next_bvalid, next_rvalid;
   logic [1:0]  next_bresp, next_rresp;
   logic [31:0] next_rdata;

   // one write at a time: both halves parked, then committed together
   assign wr = '{en: aw_held && w_held && !s_axi_bvalid, idx: awaddr_q[11:2],
                 data: wdata_q, be: wstrb_q};
   assign rd = '{en: s_axi_arvalid && s_axi_arready, idx: s_axi_araddr[11:2]};

   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_awaddr  = awaddr_q;
      next_wdata   = wdata_q;
      next_wstrb   = wstrb_q;
      next_bvalid  = s_axi_bvalid;
      next_bresp   = s_axi_bresp;
      next_rvalid  = s_axi_rvalid;
      next_rdata   = s_axi_rdata;
      next_rresp   = s_axi_rresp;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_wdata  = s_axi_wdata;
         next_wstrb  = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
         next_bvalid = 1'b0;
      if (wr.en) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = ccfc_mapped(wr.idx) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready)
         next_rvalid = 1'b0;
      if (rd.en) begin
         next_rvalid = 1'b1;
         next_rdata  = rd_data;
         next_rresp  = ccfc_mapped(rd.idx) ? RESP_OKAY : RESP_SLVERR;
      end
      next_awready = !next_aw_held && !next_bvalid;
      next_wready  = !next_w_held && !next_bvalid;
      next_arready = !next_rvalid;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         awaddr_q      <= 12'h000;
         wdata_q       <= 32'h00000000;
         wstrb_q       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_arready <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         aw_held       <= next_aw_held;
         w_held        <= next_w_held;
         awaddr_q      <= next_awaddr;
         wdata_q       <= next_wdata;
         wstrb_q       <= next_wstrb;
         s_axi_awready <= next_awready;
         s_axi_wready  <= next_wready;
         s_axi_arready <= next_arready;
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
         s_axi_rvalid  <= next_rvalid;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
      end
   end

endmodule

// ---- rtl/ccfc_infilt.sv ----
// pin synchroniser, three-sample noise filter and edge detector
`timescale 1ns/1ps
module ccfc_infilt
   import ccfc_pkg::*;
(
   // clock and reset
   input  wire logic core_clk,
   input  wire logic arst_n,
   // pin and control
   input  wire logic pin_raw,
   input  wire logic filt_en,
   // edges of the filtered level
   output logic      rise,
   output logic      fall
);
   logic       sync1, sync2, lvl, prev, next_lvl;
   logic [1:0] hist;

   // with filt_en set, a change is accepted only after every sample in the window agrees; with it clear, at once
   always_comb begin
      next_lvl = lvl;
      if (!filt_en || ((sync2 == hist[0]) && (sync2 == hist[1])))
         next_lvl = sync2;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         hist  <= 2'h0;
         lvl   <= 1'b0;
         prev  <= 1'b0;
      end else begin
         sync1 <= pin_raw;
         sync2 <= sync1;
         hist  <= {hist[0], sync2};
         lvl   <= next_lvl;
         prev  <= lvl;
      end
   end

   assign rise = lvl && !prev;
   assign fall = !lvl && prev;

   a_filter_window: assert property (@(posedge core_clk) disable iff (!arst_n)
      ($past(filt_en) && $changed(lvl)) |->
         ($past(sync2) == lvl && $past(sync2, 2) == lvl && $past(sync2, 3) == lvl))
      else $error("filtered level changed without matching samples");

endmodule

// ---- rtl/ccfc_top.sv ----
// four-channel capture/compare flag control with AXI4-Lite registers
// Notes on behaviour
// - channel A in capture sets its flag on the chosen pin edge.
// - channel B in capture sets its flag on the chosen pin edge.
// - channel C in capture sets its flag on the chosen pin edge.
// - channel D in capture sets its flag on the chosen pin edge.
// - in compare, a channel flag sets when counter equals its general register.
// - C and D compare flags set also while they serve as buffers.
// - overflow flag sets whenever the 16-bit counter wraps, in every mode.
// - control bits 1:0 of each channel choose the capture edge.
// - mode select bit: 0 picks compare, 1 picks capture.
// - I/O control registers act only in timer mode, not PWM modes.
// - trigger filter acts only in triggered-pulse mode with trigger edge nonzero.
// - channel pin filters act only while capture is in use.
// - top bit and bit 3 of each I/O control register (A/B and C/D) read 1.
// - a valid capture edge copies the counter into the general register; here C and D do not copy it while they serve as buffers.
// - flag clears only on a zero written after reading it as one.
// - C buffer select set makes register C the buffer of register A.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module ccfc_top
   import ccfc_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   // AXI4-Lite write
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // timer pins
   input  wire logic        chan_a_pin,
   input  wire logic        chan_b_pin,
   input  wire logic        chan_c_pin,
   input  wire logic        chan_d_pin,
   input  wire logic        external_trigger_pin,
   // events out
   output logic             irq,
   output logic             trig_event
);
   ccfc_wr_s    wr;
   ccfc_rd_s    rd;
   logic [31:0] rd_data;

   logic [7:0]  timer_mode_reg, next_mode;
   logic [7:0]  io_control_ab, next_ioc_ab;
   logic [7:0]  io_control_cd, next_ioc_cd;
   logic [7:0]  input_filter_reg, next_filter;
   logic [1:0]  trig_edge, next_trig_edge;
   logic [4:0]  imask, next_imask;
   logic [3:0]  flags, next_flags;
   logic        counter_wrap_flag, next_wrap_flag;
   logic [4:0]  armed, next_armed;
   logic [15:0] timer_counter_value, next_counter;
   logic [15:0] gr [4];
   logic [15:0] next_gr [4];
   logic        next_irq, next_trig_event;

   logic        w_mode, w_stat, w_ioc_ab, w_ioc_cd, w_filt, w_trig, w_imask;
   logic        run, triggered_pulse_mode_n, bfc, bfd, wrap, pulse_mode;
   logic [2:0]  ctl [4];
   logic [3:0]  chan_timer, cap_act, hit, cap_evt, cmp_evt;
   logic [4:0]  pin_vec, filt_en, rise, fall;

   ccfc_axil u_axil (
      .core_clk      (core_clk),
      .arst_n        (arst_n),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wr            (wr),
      .rd            (rd),
      .rd_data       (rd_data)
   );

   // byte-lane 0 carries every 8-bit register
   assign w_mode   = wr.en && wr.be[0] && (wr.idx == IDX_MODE);
   assign w_stat   = wr.en && wr.be[0] && (wr.idx == IDX_STATUS);
   assign w_ioc_ab = wr.en && wr.be[0] && (wr.idx == IDX_IOC_AB);
   assign w_ioc_cd = wr.en && wr.be[0] && (wr.idx == IDX_IOC_CD);
   assign w_filt   = wr.en && wr.be[0] && (wr.idx == IDX_FILTER);
   assign w_trig   = wr.en && wr.be[0] && (wr.idx == IDX_TRIG);
   assign w_imask  = wr.en && wr.be[0] && (wr.idx == IDX_IMASK);

   assign run        = timer_mode_reg[MODE_START];
   assign triggered_pulse_mode_n     = timer_mode_reg[MODE_TRIGGERED_PULSE_MODE_N];
   assign bfc        = timer_mode_reg[MODE_BFC];
   assign bfd        = timer_mode_reg[MODE_BFD];
   assign pulse_mode = !triggered_pulse_mode_n && (trig_edge != 2'h0);
   assign wrap       = run && (timer_counter_value == COUNT_TOP);

   assign ctl[0] = io_control_ab[2:0];
   assign ctl[1] = io_control_ab[6:4];
   assign ctl[2] = io_control_cd[2:0];
   assign ctl[3] = io_control_cd[6:4];

   // channel A has no PWM select; B..D drop out of timer mode individually
   assign chan_timer = {triggered_pulse_mode_n & ~timer_mode_reg[2], triggered_pulse_mode_n & ~timer_mode_reg[1],
                        triggered_pulse_mode_n & ~timer_mode_reg[0], triggered_pulse_mode_n};

   assign pin_vec = {external_trigger_pin, chan_d_pin, chan_c_pin, chan_b_pin, chan_a_pin};
   assign filt_en[4] = pulse_mode && input_filter_reg[FILT_TRIG];

   genvar g;
   for (g = 0; g < 4; g++) begin : g_chan
      assign cap_act[g] = chan_timer[g] && ctl[g][CAP_SEL];
      assign filt_en[g] = cap_act[g] && input_filter_reg[g];
      assign hit[g] = (ctl[g][1:0] == 2'h0) ? rise[g] :
                      (ctl[g][1:0] == 2'h1) ? fall[g] : (rise[g] | fall[g]);
      assign cap_evt[g] = cap_act[g] && hit[g];
      // C and D still compare while buffering
      assign cmp_evt[g] = !cap_act[g] && run && (timer_counter_value == gr[g]);
   end

   for (g = 0; g < 5; g++) begin : g_filt
      ccfc_infilt u_filt (
         .core_clk (core_clk),
         .arst_n   (arst_n),
         .pin_raw  (pin_vec[g]),
         .filt_en  (filt_en[g]),
         .rise     (rise[g]),
         .fall     (fall[g])
      );
   end

   // plain control registers; forced bits never store a zero
   always_comb begin
      next_mode      = w_mode   ? (wr.data[7:0] | MODE_ONES) : timer_mode_reg;
      next_ioc_ab    = w_ioc_ab ? (wr.data[7:0] | IOC_ONES) : io_control_ab;
      next_ioc_cd    = w_ioc_cd ? (wr.data[7:0] | IOC_ONES) : io_control_cd;
      next_filter    = w_filt   ? wr.data[7:0] : input_filter_reg;
      next_trig_edge = w_trig   ? wr.data[1:0] : trig_edge;
      next_imask     = w_imask  ? wr.data[4:0] : imask;
      next_trig_event = pulse_mode && ((trig_edge[0] && rise[4]) || (trig_edge[1] && fall[4]));
   end

   // counter and general registers; a counter write beats the increment, capture/buffer updates beat a general register write
   always_comb begin
      next_gr      = gr;
      next_counter = timer_counter_value;
      if (run)
         next_counter = timer_counter_value + 16'h0001;
      if (wr.en && (wr.idx == IDX_COUNT))
         next_counter = ccfc_merge16(timer_counter_value, wr.data[15:0], wr.be[1:0]);
      for (int i = 0; i < 4; i++) begin
         if (wr.en && (wr.idx == (IDX_GR_A + 10'(i))))
            next_gr[i] = ccfc_merge16(gr[i], wr.data[15:0], wr.be[1:0]);
      end
      for (int i = 0; i < 4; i++) begin
         if (cap_evt[i])
            next_gr[i] = timer_counter_value;
      end
      if (cmp_evt[0] && bfc)
         next_gr[0] = gr[2];
      if (cmp_evt[1] && bfd)
         next_gr[1] = gr[3];
      // capture pushes the old value into the buffer, not the counter
      if (cap_evt[0] && bfc)
         next_gr[2] = gr[0];
      else if (cap_evt[2] && bfc)
         next_gr[2] = gr[2];
      if (cap_evt[1] && bfd)
         next_gr[3] = gr[1];
      else if (cap_evt[3] && bfd)
         next_gr[3] = gr[3];
   end

   // status flags: read-one arms, write-zero clears, a new event always wins
   always_comb begin
      next_flags     = flags;
      next_wrap_flag = counter_wrap_flag;
      next_armed     = armed;
      if (w_stat) begin
         for (int i = 0; i < 4; i++) begin
            if (!wr.data[i] && armed[i])
               next_flags[i] = 1'b0;
         end
         if (!wr.data[7] && armed[4])
            next_wrap_flag = 1'b0;
         next_armed = 5'h00;
      end
      if (rd.en && (rd.idx == IDX_STATUS))
         next_armed = {counter_wrap_flag, flags};
      next_flags     = next_flags | cap_evt | cmp_evt;
      next_wrap_flag = next_wrap_flag | wrap;
      next_irq       = |({next_wrap_flag, next_flags} & next_imask);
   end

   always_comb begin
      rd_data = 32'h00000000;
      unique case (rd.idx)
         IDX_MODE:   rd_data[7:0] = timer_mode_reg;
         IDX_STATUS: rd_data[7:0] = {counter_wrap_flag, STAT_ONES, flags};
         IDX_IOC_AB: rd_data[7:0] = io_control_ab;
         IDX_IOC_CD: rd_data[7:0] = io_control_cd;
         IDX_FILTER: rd_data[7:0] = input_filter_reg;
         IDX_TRIG:   rd_data[1:0] = trig_edge;
         IDX_COUNT:  rd_data[15:0] = timer_counter_value;
         IDX_IMASK:  rd_data[4:0] = imask;
         default: begin
            for (int i = 0; i < 4; i++) begin
               if (rd.idx == (IDX_GR_A + 10'(i)))
                  rd_data[15:0] = gr[i];
            end
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         timer_mode_reg      <= RST_MODE;
         io_control_ab       <= RST_IOC;
         io_control_cd       <= RST_IOC;
         input_filter_reg    <= RST_FILTER;
         trig_edge           <= RST_TRIG;
         imask               <= RST_IMASK;
         flags               <= 4'h0;
         counter_wrap_flag   <= 1'b0;
         armed               <= 5'h00;
         timer_counter_value <= RST_COUNT;
         gr                  <= '{default: RST_GR};
         irq                 <= 1'b0;
         trig_event          <= 1'b0;
      end else begin
         timer_mode_reg      <= next_mode;
         io_control_ab       <= next_ioc_ab;
         io_control_cd       <= next_ioc_cd;
         input_filter_reg    <= next_filter;
         trig_edge           <= next_trig_edge;
         imask               <= next_imask;
         flags               <= next_flags;
         counter_wrap_flag   <= next_wrap_flag;
         armed               <= next_armed;
         timer_counter_value <= next_counter;
         gr                  <= next_gr;
         irq                 <= next_irq;
         trig_event          <= next_trig_event;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   // armed only by a status read that saw the flag at one
   sequence s_read_a_set;
      armed[0] && flags[0];
   endsequence
   sequence s_write_a_zero;
      w_stat && !wr.data[0] && !cap_evt[0] && !cmp_evt[0];
   endsequence

   a_cap_flag_a: assert property ((chan_timer[0] && ctl[0][CAP_SEL] && hit[0]) |=> flags[0])
      else $error("capture edge on A did not set its flag");
   a_cap_flag_b: assert property ((cap_act[1] && (ctl[1][1:0] == 2'h0) && rise[1]) |=> flags[1])
      else $error("rising capture on B did not set its flag");
   a_cap_flag_c: assert property ((cap_act[2] && (ctl[2][1:0] == 2'h1) && fall[2]) |=> flags[2])
      else $error("falling capture on C did not set its flag");
   a_cap_edge_d: assert property ((cap_act[3] && (ctl[3][1:0] == 2'h0) && fall[3]) |-> !cap_evt[3])
      else $error("wrong edge captured on D");
   a_cmp_match: assert property ((!cap_act[1] && run && (timer_counter_value == gr[1])) |=> flags[1])
      else $error("compare match on B did not set its flag");
   a_buf_match: assert property ((bfc && !cap_act[2] && run && (timer_counter_value == gr[2])) |=> flags[2])
      else $error("buffer compare on C did not set its flag");
   // a same-cycle counter write legally overrides the wrap to zero
   a_wrap_flag: assert property ((wrap && !(wr.en && (wr.idx == IDX_COUNT)))
      |=> (counter_wrap_flag && (timer_counter_value == 16'h0000)))
      else $error("counter wrap not flagged");
   a_pwm_ignore: assert property (!triggered_pulse_mode_n |-> (cap_act == 4'h0))
      else $error("capture active outside timer mode");
   a_capture_copy: assert property (cap_evt[0] |=> (gr[0] == $past(timer_counter_value)))
      else $error("capture did not copy the counter");
   a_buffer_copy: assert property ((cap_evt[0] && bfc) |=> (gr[2] == $past(gr[0])))
      else $error("buffer did not receive the old A value");
   a_flag_clear: assert property (s_read_a_set ##0 s_write_a_zero |=> !flags[0])
      else $error("flag not cleared by zero after one was read");
   a_flag_keep: assert property ((flags[0] && !(w_stat && !wr.data[0] && armed[0])) |=> flags[0])
      else $error("flag cleared without the read-then-zero sequence");
   a_forced_ones: assert property ((io_control_ab[3] && io_control_ab[7]) ##0 (io_control_cd[3] && io_control_cd[7]))
      else $error("forced-one bit of an I/O control register lost");
   a_irq_level: assert property (irq == |({counter_wrap_flag, flags} & imask))
      else $error("interrupt output disagrees with masked status");

endmodule

// ---- tb/ccfc_pin_model.sv ----
// pin side model: drives the four capture pins and the trigger pin
`timescale 1ns/1ps
module ccfc_pin_model (
   // clock
   input  wire logic       core_clk,
   // levels asked by the bench
   input  wire logic [3:0] want,
   input  wire logic       want_trig,
   // pins
   output logic [3:0]      pins,
   output logic            trig_pin
);
   initial pins = 4'h0;
   initial trig_pin = 1'b0;
   // levels move just after an edge, like a real source
   always @(posedge core_clk) begin
      pins     <= want;
      trig_pin <= want_trig;
   end
endmodule

// ---- tb/tb_capture_compare_flag_control.sv ----
// self-checking bench for the capture/compare flag control block
`timescale 1ns/1ps
module tb_capture_compare_flag_control
   import ccfc_pkg::*;
;
   logic        core_clk = 0, arst_n = 0, trig_pin, want_trig = 0;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid, irq, trig_event;
   logic [1:0]  bresp, rresp, last_bresp = 0, last_rresp = 0;
   logic [3:0]  want = 0, pins;
   int          error_cnt = 0, comparisons = 0;
   always #4 core_clk = ~core_clk;
   ccfc_pin_model pm_u (.core_clk(core_clk), .want(want), .want_trig(want_trig),
      .pins(pins), .trig_pin(trig_pin));
   ccfc_top dut_u (.core_clk(core_clk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .chan_a_pin(pins[0]), .chan_b_pin(pins[1]), .chan_c_pin(pins[2]),
      .chan_d_pin(pins[3]), .external_trigger_pin(trig_pin), .irq(irq),
      .trig_event(trig_event));
   task automatic end_of_test();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // handshakes are judged on values settled at the falling edge before
   task automatic wr(input logic [9:0] i, input logic [31:0] d);
      logic a, w, b;
      @(posedge core_clk);
      awaddr <= {i, 2'h0};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(negedge core_clk);
         a = awvalid && awready;
         w = wvalid && wready;
         b = bvalid;
         last_bresp = bresp;
         @(posedge core_clk);
         if (a) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         if (b) begin
            bready <= 1'b0;
            return;
         end
      end
      error_cnt++;
      end_of_test();
   endtask
   task automatic rc(input string nm, input logic [9:0] i, input logic [31:0] e);
      logic a, r;
      logic [31:0] d;
      @(posedge core_clk);
      araddr <= {i, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(negedge core_clk);
         a = arvalid && arready;
         r = rvalid;
         d = rdata;
         last_rresp = rresp;
         @(posedge core_clk);
         if (a) arvalid <= 1'b0;
         if (r) begin
            rready <= 1'b0;
            chk(nm, e, d);
            return;
         end
      end
      error_cnt++;
      end_of_test();
   endtask
   task automatic sc_reset();
      rc("ioc_ab", IDX_IOC_AB, 32'h88);
      rc("ioc_cd", IDX_IOC_CD, 32'h88);
      rc("status", IDX_STATUS, 32'h70);
      wr(IDX_IOC_AB, 32'h0);
      wr(IDX_IOC_CD, 32'h0);
      chk("wr_resp", {30'h0, RESP_OKAY}, {30'h0, last_bresp});
      rc("ioc_ab_ones", IDX_IOC_AB, 32'h88);
      rc("ioc_cd_ones", IDX_IOC_CD, 32'h88);
      rc("unmapped", 10'h3FF, 32'h0);
      chk("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, last_rresp});
   endtask
   task automatic sc_capture();
      wr(IDX_COUNT, 32'h1234);
      wr(IDX_IMASK, 32'h0F);
      wr(IDX_IOC_AB, 32'h44);
      wr(IDX_IOC_CD, 32'h44);
      // register C buffers A during this capture
      wr(IDX_MODE, 32'h58);
      want <= 4'hF;
      repeat (8) @(posedge core_clk);
      chk("irq_set", 32'h1, {31'h0, irq});
      rc("flags_cap", IDX_STATUS, 32'h7F);
      rc("gr_a_cap", IDX_GR_A, 32'h1234);
      rc("gr_c_buf", IDX_GR_A + 10'h2, 32'hFFFF);
      // a write of ones, then a zero without a fresh read, must not clear
      wr(IDX_STATUS, 32'hFF);
      wr(IDX_STATUS, 32'h00);
      rc("flags_kept", IDX_STATUS, 32'h7F);
      wr(IDX_STATUS, 32'h00);
      rc("flags_clr", IDX_STATUS, 32'h70);
      chk("irq_clr", 32'h0, {31'h0, irq});
   endtask
   task automatic sc_compare();
      wr(IDX_IOC_AB, 32'h88);
      wr(IDX_IOC_CD, 32'h88);
      want <= 4'h0;
      wr(IDX_GR_A, 32'h5);
      wr(IDX_COUNT, 32'hFFF0);
      wr(IDX_IMASK, 32'h10);
      wr(IDX_MODE, 32'hC8);
      repeat (40) @(posedge core_clk);
      wr(IDX_MODE, 32'h48);
      // C holds the old A value 0xFFFF, so it matches just before the wrap
      rc("flags_cmp", IDX_STATUS, 32'hF5);
      chk("irq_wrap", 32'h1, {31'h0, irq});
   endtask
   task automatic sc_trig();
      int pulses = 0;
      wr(IDX_STATUS, 32'h00);
      wr(IDX_MODE, 32'h40);
      wr(IDX_IOC_AB, 32'h44);
      wr(IDX_TRIG, 32'h1);
      wr(IDX_FILTER, 32'h1F);
      want_trig <= 1'b1;
      want <= 4'hF;
      for (int n = 0; n < 20; n++) begin
         @(negedge core_clk);
         if (trig_event) pulses++;
      end
      chk("trig_pulses", 32'h1, 32'(pulses));
      rc("flags_triggered_pulse_mode", IDX_STATUS, 32'h70);
   endtask
   initial begin
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      sc_reset();
      sc_capture();
      sc_compare();
      sc_trig();
      end_of_test();
   end
endmodule
